// ===== src/cmd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module cmd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             ready_reg;
  logic             ready_next;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction

  // Ready is registered; it falls the cycle the last slot is taken
  assign push = in_valid_in & ready_reg;
  assign pop  = out_ready_in & (count_reg != '0);

  always_comb begin
    wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
    count_next  = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
    ready_next = (count_next != CW'(DEPTH));
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      ready_reg  <= ready_next;
    end
  end

  // Storage needs no reset; only counted words are ever read
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  assign in_ready_out  = ready_reg;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];

endmodule // cmd_fifo
`default_nettype wire

// ===== src/eight_stage_load_shift_register.sv
// Eight-stage shift register with synchronous parallel load and three taps
//
// Notes on behaviour
// - Eight stages change only on a shift clock rising edge; falling edges do nothing.
// - Load select high at the edge loads all eight parallel bits.
// - Load select low: each stage moves one toward the end, first takes serial.
// - A serial bit reaches the first tap after six shifts, last after eight.
// - Only stages five, six and seven are visible as outputs.
// - Stages hold their value while the shift clock stands still, once queued edges have drained.
`timescale 1ns/10ps
`default_nettype none
`include "shift8_regs.svh"

module eight_stage_load_shift_register
  import shift8_pkg::*;
(
  // System clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_n_in,
  // Host side
  input  wire logic                    shift_clock_in,
  input  wire logic                    load_select_in,
  input  wire logic                    serial_data_in,
  input  wire logic [`STAGE_COUNT-1:0] parallel_data_in,
  // Flow control
  input  wire logic                    hold_in,
  output logic                         cmd_ready_out,
  output logic                         edge_dropped_out,
  // Taps
  output logic [`TAP_COUNT-1:0]        stage_taps_out
);

  logic                    shift_rise;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [`CMD_WIDTH-1:0]   fifo_out_data;
  logic [`CMD_WIDTH-1:0]   cmd_word;
  logic                    apply;
  core_state_t             state_reg;
  core_state_t             state_next;
  logic [`STAGE_COUNT-1:0] stage_reg;
  logic [`STAGE_COUNT-1:0] stage_next;
  logic                    drop_reg;
  logic                    drop_next;

  // Only the rising edge makes an event; falling edges are ignored
  rise_detect u_rise (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .level_in   (shift_clock_in),
    .rise_out   (shift_rise)
  );

  // Inputs are captured in the cycle the edge is seen
  assign cmd_word = {load_select_in, serial_data_in, parallel_data_in};

  // Queue absorbs edges while the core is held
  cmd_fifo #(
    .WIDTH (`CMD_WIDTH),
    .DEPTH (`CMD_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (shift_rise),
    .in_data_in    (cmd_word),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (apply)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (hold_in) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!hold_in) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  assign apply = fifo_out_valid & (state_reg == ST_RUN) & ~hold_in;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stages move only when a queued edge is applied, else they hold
  always_comb begin
    stage_next = stage_reg;
    if (apply) begin
      if (fifo_out_data[`CMD_LOAD_BIT]) begin
        stage_next = fifo_out_data[`STAGE_COUNT-1:0];
      end else begin
        stage_next = {stage_reg[`STAGE_COUNT-2:0], fifo_out_data[`CMD_SERIAL_BIT]};
      end
    end
  end

  // Deliberately no reset: contents stay unknown until loaded or filled
  always_ff @(posedge ref_clk_in) begin
    stage_reg <= stage_next;
  end

  // An edge arriving with the queue full is lost and reported
  always_comb begin
    drop_next = shift_rise & ~fifo_in_ready;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      drop_reg <= `DROP_RST;
    end else begin
      drop_reg <= drop_next;
    end
  end

  // Stage 0 feeds stage 5 after five shifts, stage 7 after seven
  assign stage_taps_out   = stage_reg[`STAGE_COUNT-1:`TAP_LSB];
  assign cmd_ready_out    = fifo_in_ready;
  assign edge_dropped_out = drop_reg;

endmodule // eight_stage_load_shift_register
`default_nettype wire

// ===== src/rise_detect.sv
// Rising-edge detector for a level sampled on the system clock
`timescale 1ns/10ps
`default_nettype none
`include "shift8_regs.svh"

module rise_detect (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // Level and edge
  input  wire logic level_in,
  output logic      rise_out
);

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = level_in;
  end

  // Reset high so a level already high at release is not seen as an edge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prev_reg <= `EDGE_PREV_RST;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise_out = level_in & ~prev_reg;

endmodule // rise_detect
`default_nettype wire

// ===== src/shift8_pkg.sv
// Types for the eight-stage load/shift register
package shift8_pkg;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } core_state_t;

endpackage

// ===== src/shift8_regs.svh
// Constants for the eight-stage load/shift register
`ifndef SHIFT8_REGS_SVH
`define SHIFT8_REGS_SVH

`define STAGE_COUNT    8
`define TAP_COUNT      3
`define TAP_LSB        5
`define CMD_FIFO_DEPTH 4
`define CMD_WIDTH      10
`define CMD_LOAD_BIT   9
`define CMD_SERIAL_BIT 8
`define EDGE_PREV_RST  1'b1
`define DROP_RST       1'b0

`endif

// ===== test/host_model.sv
// Host logic model driving the register inputs
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic      ref_clk_in,
  // Driven lines
  output var logic       shift_clock_out,
  output var logic [9:0] cmd_out
);
  initial begin
    shift_clock_out = 1'b0;
    cmd_out = 10'h0;
  end
  task automatic op(input logic [9:0] c);
    @(negedge ref_clk_in);
    cmd_out = c;
    shift_clock_out = 1'b1;
    @(negedge ref_clk_in);
    // Inverted so a late sample shows up
    cmd_out = ~c;
    shift_clock_out = 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// ===== test/shift8_asserts.sv
// Port checker for the load/shift register
`timescale 1ns/10ps
`default_nettype none
module shift8_asserts (
  // Watched ports
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  input wire logic       shift_clock_in,
  input wire logic       load_select_in,
  input wire logic       serial_data_in,
  input wire logic [7:0] parallel_data_in,
  input wire logic       hold_in,
  input wire logic       cmd_ready_out,
  input wire logic       edge_dropped_out,
  input wire logic [2:0] stage_taps_out
);
  logic       prev_reg = 1'b1;
  logic       ld_reg   = 1'b0;
  logic [3:0] calm_reg = 4'h0;
  wire        rise     = shift_clock_in & ~prev_reg;
  wire        acc      = rise & cmd_ready_out;
  // Only judge latency once a held queue has drained
  wire        take     = acc & calm_reg[3];
  always_ff @(posedge ref_clk_in) begin
    prev_reg <= rst_n_in ? shift_clock_in : 1'b1;
    ld_reg   <= ld_reg | (take & load_select_in);
    calm_reg <= hold_in ? 4'h0 : calm_reg + {3'h0, ~calm_reg[3]};
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Accepted edge, then a cycle without hold so the core may apply it
  sequence s_load; take & load_select_in ##1 !hold_in; endsequence
  sequence s_shift; take & ~load_select_in & $past(ld_reg, 3) ##1 !hold_in; endsequence
  sequence s_held; hold_in [*3]; endsequence
  chk_load_taps: assert property (
    s_load |-> ##2 stage_taps_out == $past(parallel_data_in[7:5], 3))
    else $error("taps differ from load");
  chk_shift_taps: assert property (
    s_shift |-> ##2 stage_taps_out[2:1] == $past(stage_taps_out[1:0], 2))
    else $error("taps did not shift");
  // An edge taken two cycles back is the only one that can move the taps now
  chk_taps_still: assert property (
    $past(ld_reg, 3) && !$past(acc, 2) && calm_reg[3] |-> $stable(stage_taps_out))
    else $error("taps moved without edge");
  chk_hold_freeze: assert property (
    s_held ##0 $past(ld_reg, 3) |-> $stable(stage_taps_out))
    else $error("taps moved under hold");
  chk_reset_keep: assert property (@(posedge ref_clk_in) disable iff (1'b0)
    !rst_n_in && ld_reg |=> $stable(stage_taps_out))
    else $error("reset touched taps");
  chk_drop_pulse: assert property (rise && !cmd_ready_out |=> edge_dropped_out)
    else $error("drop not flagged");
  chk_no_drop: assert property (!rise |=> !edge_dropped_out)
    else $error("spurious drop");
endmodule // shift8_asserts
bind eight_stage_load_shift_register shift8_asserts u_chk (.ref_clk_in, .rst_n_in,
  .shift_clock_in, .load_select_in, .serial_data_in, .parallel_data_in, .hold_in,
  .cmd_ready_out, .edge_dropped_out, .stage_taps_out);
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the load/shift register
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       ref_clk_in = 1'b0;
  logic       rst_n_in   = 1'b0;
  logic       hold_in    = 1'b0;
  logic       shift_clock, cmd_ready, dropped;
  logic [9:0] cmd;
  logic [7:0] model, kept;
  logic [2:0] taps;
  int         errors = 0;
  int         check_count = 0;
  host_model hm (.ref_clk_in, .shift_clock_out(shift_clock), .cmd_out(cmd));
  eight_stage_load_shift_register DUT (.ref_clk_in, .rst_n_in,
    .shift_clock_in(shift_clock), .load_select_in(cmd[9]), .serial_data_in(cmd[8]),
    .parallel_data_in(cmd[7:0]), .hold_in, .cmd_ready_out(cmd_ready),
    .edge_dropped_out(dropped), .stage_taps_out(taps));
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [7:0] nxt(logic [7:0] st, logic [9:0] c);
    return c[9] ? c[7:0] : {st[6:0], c[8]};
  endfunction
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic step(input logic l, input int wt);
    logic [9:0] c;
    c = {l, 9'($urandom)};
    hm.op(c);
    model = nxt(model, c);
    repeat (wt) @(negedge ref_clk_in);
  endtask
  initial begin
    #100000;
    errors++;
    complete_run;
  end
  initial begin
    void'($urandom(66901));
    repeat (4) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    step(1'b1, 2);
    check(taps, model[7:5]);
    for (int i = 0; i < 40; i++) begin
      step(($urandom % 4) == 0, 2);
      check(taps, model[7:5]);
    end
    for (int i = 0; i < 8; i++) step(1'b0, 0);
    repeat (2) @(negedge ref_clk_in);
    check(taps, model[7:5]);
    $display("test load and shift done");
    hold_in = 1'b1;
    kept = model;
    for (int i = 0; i < 4; i++) step(1'b0, 0);
    hm.op(10'h3ff);
    check_flag(dropped, 1'b1);
    check_flag(cmd_ready, 1'b0);
    check(taps, kept[7:5]);
    hold_in = 1'b0;
    repeat (12) @(negedge ref_clk_in);
    check(taps, model[7:5]);
    check_flag(cmd_ready, 1'b1);
    check_flag(dropped, 1'b0);
    $display("test hold and drop done");
    repeat (30) @(negedge ref_clk_in);
    check(taps, model[7:5]);
    rst_n_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    check(taps, model[7:5]);
    step(1'b0, 2);
    check(taps, model[7:5]);
    $display("test idle and reset done");
    complete_run;
  end
endmodule // tb
`default_nettype wire
